// ---- pkg/spi_port_consts.svh ----
`ifndef SPI_PORT_CONSTS_SVH
`define SPI_PORT_CONSTS_SVH

// Register indices; the byte address on the bus is four times the index.
`define REG_DATA_IDX 4'h8
`define REG_CTL_IDX 4'h9
`define REG_CFG_IDX 4'ha
`define REG_MODE_IDX 4'hb

// Control register bit positions.
`define CTL_CS 0
`define CTL_MST 1
`define CTL_ODIS 2
`define CTL_RDEN 3
`define CTL_INC 4
`define CTL_SHARE 5
`define CTL_BUSY 6

// Clock and pin configuration, and clock mode bit positions.
`define CFG_FUNC 7
`define MODE_CPOL 0
`define MODE_CPHA 1

// Reset values.
`define DATA_RST 8'h00
`define CTL_RST 8'h11
`define CFG_RST 8'h05
`define MODE_RST 8'h00

// Link frame codes.
`define CMD_WRITE 8'h00
`define CMD_READ 8'h80
`define SLAVE_KEY 8'ha5

// Least ratio of system clock to link clock for a slave link.
`define LINK_RATIO 5
// Host half period in system cycles, rounded up so the ratio holds.
`define HOST_HALF_CYC ((`LINK_RATIO + 1) / 2)
// Bits in one host frame: command, three address bytes, one data byte.
`define HOST_FRAME_BITS 40

`endif

// ---- pkg/spi_port_pkg.sv ----
package spi_port_pkg;

    // Master byte engine states.
    typedef enum logic [1:0] {
        M_IDLE = 2'b01,
        M_RUN = 2'b10
    } master_state_type;

    // Far end frame generator states.
    typedef enum logic [2:0] {
        H_IDLE = 3'b001,
        H_LOW = 3'b010,
        H_HIGH = 3'b100
    } host_state_type;

endpackage

// ---- pkg/spi_link_if.sv ----
// Four line serial link; each pin is resolved from the drivers' enables.
interface spi_link_if;
    logic dev_cs_o; // Device chip-select drive value.
    logic dev_cs_oe; // Device drives chip-select.
    logic dev_sck_o; // Device clock drive value.
    logic dev_sck_oe; // Device drives the clock.
    logic dev_dout_o; // Device data-out drive value.
    logic dev_dout_oe; // Device drives data-out.
    logic far_cs_o; // Far end chip-select drive value.
    logic far_cs_oe; // Far end drives chip-select.
    logic far_sck_o; // Far end clock drive value.
    logic far_sck_oe; // Far end drives the clock.
    logic far_din_o; // Far end drive value on the device data-in line.
    logic far_din_oe; // Far end drives the device data-in line.
    logic cs; // Resolved chip-select, pulled high.
    logic serial_clock_pin; // Resolved clock, pulled low.
    logic dout; // Resolved device data-out line, pulled low.
    logic serial_in_pin; // Resolved device data-in line, pulled low.

    assign cs = dev_cs_oe ? dev_cs_o : (far_cs_oe ? far_cs_o : 1'b1);
    assign serial_clock_pin = dev_sck_oe ? dev_sck_o :
        (far_sck_oe ? far_sck_o : 1'b0);
    assign dout = dev_dout_oe ? dev_dout_o : 1'b0;
    assign serial_in_pin = far_din_oe ? far_din_o : 1'b0;

    modport device(input cs, serial_clock_pin, dout, serial_in_pin,
        output dev_cs_o, dev_cs_oe, dev_sck_o, dev_sck_oe,
        dev_dout_o, dev_dout_oe);
    modport far(input cs, serial_clock_pin, dout, serial_in_pin,
        output far_cs_o, far_cs_oe, far_sck_o, far_sck_oe,
        far_din_o, far_din_oe);
endinterface

// ---- rtl/serial_clock_divider.sv ----
// Half period tick generator for the master clock.
module serial_clock_divider #(
    parameter int DIV_W = 7
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic [DIV_W-1:0] div_i,
    output logic tick_o
);
    logic [DIV_W-1:0] cnt; // Cycles spent in the current half period.

    // One tick every div_i plus one cycles gives one clock edge each.
    assign tick_o = run_i && (cnt == div_i);

    // The count restarts whenever the engine is idle.
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i || tick_o) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end
endmodule // serial_clock_divider

// ---- rtl/spi_port_device.sv ----
// Contract
// - Starts as slave; master only when enabled.
// - Function bit routes pins to serial port.
// - Clock equals system over twice speed-plus-one.
// - Each data access makes eight clocks; reads with reception disabled and accesses while busy make none.
// - Mode register picks polarity and phase.
// - Idle clock level follows polarity.
// - Phase picks first or second sampling edge.
// - Chip-select follows control bit zero.
// - Write shifts byte out unless disabled.
// - Read with enable shifts input in.
// - Share bit joins data in and out.
// - Busy bit shows clocks still running.
// - Host clock at most fifth of system.
// - Key 0xa5 at config activates slave.
// - Host uses only modes zero or three.
// - Slave captures rising, changes falling.
// - Auto increment steps address per byte.
// - Frame: command, three address bytes, data.
// - Slave accesses registers without processor.
// - Never slave together with two-wire unit.
//
// Local design decision: register access over Wishbone.
`include "spi_port_consts.svh"

module spi_port_device (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic two_wire_slave_i,
    output logic serial_slave_active_o,
    spi_link_if.device link
);
    import spi_port_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Registers and bus decode.

    logic [7:0] data_reg; // Byte data register.
    logic [7:0] ctl; // Control register; bit 6 is stored but reads back as busy, bit 7 as zero.
    logic [7:0] cfg; // Clock speed and pin function.
    logic [7:0] mode; // Clock mode select.
    logic busy; // Master byte engine running.

    // Bus address mapped to a register address, or an unmapped marker.
    wire bus_hit = (adr_i[7:6] == 2'b00) && (adr_i[1:0] == 2'b00);
    wire [23:0] bus_addr = bus_hit ? {20'h0, adr_i[5:2]} : 24'hffffff;
    wire bus_req = cyc_i && stb_i;
    // A write takes effect only at the edge where ack is seen high.
    wire bus_wr = bus_req && we_i && ack_o && sel_i[0];
    wire bus_rd = bus_req && !we_i && ack_o;
    wire bus_data = bus_addr == {20'h0, `REG_DATA_IDX};

    // Register read mux shared by the bus and the link.
    function automatic logic [7:0] reg_read(input logic [23:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            {20'h0, `REG_DATA_IDX}: v = data_reg;
            {20'h0, `REG_CTL_IDX}: v = {1'b0, busy, ctl[5:0]};
            {20'h0, `REG_CFG_IDX}: v = cfg;
            {20'h0, `REG_MODE_IDX}: v = mode;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // Ack answers one cycle after the request and drops the cycle after.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= bus_req && !ack_o;
        end
    end

    // Read data is captured while ack is being raised.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0;
        end else if (bus_req && !ack_o) begin
            dat_o <= {24'h0, reg_read(bus_addr)};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Master byte engine.

    master_state_type mstate; // Engine state.
    logic [3:0] hcnt; // Half periods done in this byte.
    logic lvl; // Clock level relative to idle.
    logic [7:0] tx; // Outgoing bits still to send.
    logic [7:0] rx; // Incoming bits collected.
    logic out_bit; // Bit on data-out.
    logic tx_en; // Byte was started by a write.
    logic m_fin; // Pulse after the last edge.
    logic tick; // Half period elapsed.

    // The master runs only with both master and function bits set.
    wire master_en = ctl[`CTL_MST] && cfg[`CFG_FUNC];
    wire start_wr = bus_wr && bus_data && master_en && !busy;
    // A read with reception disabled just returns the stored byte.
    wire start_rd = bus_rd && bus_data && master_en && !busy &&
        ctl[`CTL_RDEN];
    wire [7:0] start_byte = start_wr ? dat_i[7:0] : data_reg;
    // In share mode the data-out line also carries the incoming bits.
    wire din_now = ctl[`CTL_SHARE] ? link.dout : link.serial_in_pin;
    wire m_lead = !hcnt[0];
    wire m_samp = mode[`MODE_CPHA] ? !m_lead : m_lead;

    assign busy = mstate == M_RUN;

    // Half period ticks set the clock rate.
    serial_clock_divider #(
        .DIV_W(7)
    ) u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(busy),
        .div_i(cfg[6:0]),
        .tick_o(tick)
    );

    // Sixteen half periods make one byte; a start while busy is dropped.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mstate <= M_IDLE;
            hcnt <= 4'h0;
            lvl <= 1'b0;
            tx <= 8'h00;
            rx <= 8'h00;
            out_bit <= 1'b0;
            tx_en <= 1'b0;
            m_fin <= 1'b0;
        end else begin
            m_fin <= 1'b0;
            case (mstate)
                M_IDLE: begin
                    if (start_wr || start_rd) begin
                        mstate <= M_RUN;
                        hcnt <= 4'h0;
                        lvl <= 1'b0;
                        tx_en <= start_wr;
                        // Phase zero needs the first bit before any edge.
                        if (!mode[`MODE_CPHA]) begin
                            out_bit <= start_byte[7];
                            tx <= {start_byte[6:0], 1'b0};
                        end else begin
                            tx <= start_byte;
                        end
                    end
                end
                M_RUN: begin
                    if (tick) begin
                        lvl <= !lvl;
                        hcnt <= hcnt + 4'h1;
                        if (m_samp) begin
                            rx <= {rx[6:0], din_now};
                        end else begin
                            out_bit <= tx[7];
                            tx <= {tx[6:0], 1'b0};
                        end
                        if (hcnt == 4'hf) begin
                            mstate <= M_IDLE;
                            m_fin <= 1'b1;
                        end
                    end
                end
                default: begin
                    mstate <= M_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Slave frame decoder.

    logic sck_q; // Clock level one cycle ago.
    logic [2:0] sbit; // Bits received in the current byte.
    logic [2:0] sbyte; // Byte index, saturating at the data phase.
    logic srd; // Frame is a read.
    logic scmd_ok; // Command byte was a known code.
    logic [23:0] saddr; // Target register address.
    logic [7:0] srx; // Incoming byte.
    logic [7:0] stx; // Outgoing read byte.
    logic sout; // Bit on data-out.
    logic slave_active; // Key has been received.

    // The two-wire unit being a slave keeps this port out of slave use.
    wire slave_ok = !ctl[`CTL_MST] && !two_wire_slave_i;
    wire slave_on = slave_active && slave_ok;
    wire sl_sel = slave_ok && !link.cs;
    wire sl_rise = sl_sel && link.serial_clock_pin && !sck_q;
    wire sl_fall = sl_sel && !link.serial_clock_pin && sck_q;
    wire [7:0] sl_byte = {srx[6:0], link.serial_in_pin};
    wire sl_done = sl_rise && (sbit == 3'h7);
    wire sl_data = sbyte == 3'h4;
    wire [23:0] sl_addr_in = {saddr[15:0], sl_byte};
    wire [23:0] sl_addr_nxt = ctl[`CTL_INC] ? saddr + 24'h1 : saddr;
    // Before activation only the key write to the config register passes.
    wire key_hit = (saddr == {20'h0, `REG_CFG_IDX}) &&
        (sl_byte == `SLAVE_KEY);
    wire lnk_we = sl_done && sl_data && !srd && scmd_ok &&
        (slave_on || key_hit);

    // Rising edges take bits in; falling edges put bits out.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sck_q <= 1'b0;
            sbit <= 3'h0;
            sbyte <= 3'h0;
            srd <= 1'b0;
            scmd_ok <= 1'b0;
            saddr <= 24'h0;
            srx <= 8'h00;
            stx <= 8'h00;
            sout <= 1'b0;
            slave_active <= 1'b0;
        end else begin
            sck_q <= link.serial_clock_pin;
            if (!sl_sel) begin
                // Chip-select high ends the frame.
                sbit <= 3'h0;
                sbyte <= 3'h0;
            end
            if (sl_rise) begin
                srx <= sl_byte;
                sbit <= sbit + 3'h1;
            end
            if (sl_done) begin
                if (!sl_data) begin
                    sbyte <= sbyte + 3'h1;
                end
                if (sbyte == 3'h0) begin
                    srd <= sl_byte == `CMD_READ;
                    scmd_ok <= (sl_byte == `CMD_READ) ||
                        (sl_byte == `CMD_WRITE);
                end else if (!sl_data) begin
                    saddr <= sl_addr_in;
                end else begin
                    saddr <= sl_addr_nxt;
                end
                if (sbyte == 3'h3) begin
                    stx <= reg_read(sl_addr_in);
                end else if (sl_data) begin
                    stx <= reg_read(sl_addr_nxt);
                end
            end
            if (lnk_we && key_hit) begin
                slave_active <= 1'b1;
            end
            if (sl_fall) begin
                sout <= stx[7];
                stx <= {stx[6:0], 1'b0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes from the bus and from the link.

    // A link write wins over a bus write in the same cycle.
    wire we_any = lnk_we || (bus_wr && bus_hit);
    wire [23:0] w_addr = lnk_we ? saddr : bus_addr;
    wire [7:0] w_data = lnk_we ? sl_byte : dat_i[7:0];

    // A master read byte lands last, so a write in the same cycle cannot replace it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data_reg <= `DATA_RST;
            ctl <= `CTL_RST;
            cfg <= `CFG_RST;
            mode <= `MODE_RST;
        end else begin
            if (we_any) begin
                case (w_addr)
                    {20'h0, `REG_DATA_IDX}: data_reg <= w_data;
                    {20'h0, `REG_CTL_IDX}: ctl <= w_data;
                    {20'h0, `REG_CFG_IDX}: cfg <= w_data;
                    {20'h0, `REG_MODE_IDX}: mode <= w_data;
                    default: ;
                endcase
            end
            if (m_fin && !tx_en) begin
                data_reg <= rx;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drive.

    assign serial_slave_active_o = slave_on;
    assign link.dev_cs_oe = master_en;
    assign link.dev_cs_o = ctl[`CTL_CS];
    assign link.dev_sck_oe = master_en;
    assign link.dev_sck_o = mode[`MODE_CPOL] ^ lvl;
    // In share mode the line is only driven while a write byte runs.
    wire m_dout_oe = !ctl[`CTL_ODIS] &&
        (!ctl[`CTL_SHARE] || (busy && tx_en));
    wire s_dout_oe = slave_on && cfg[`CFG_FUNC] && !link.cs && srd &&
        scmd_ok && sl_data;
    assign link.dev_dout_oe = master_en ? m_dout_oe : s_dout_oe;
    assign link.dev_dout_o = master_en ? out_bit : sout;
endmodule // spi_port_device

// ---- rtl/spi_port_host.sv ----
`include "spi_port_consts.svh"

// Far end: slave frame generator and master mode peripheral.
module spi_port_host #(
    parameter int HALF_CYC = `HOST_HALF_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic read_i,
    input wire logic [23:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic busy_o,
    output logic done_o,
    output logic [7:0] rdata_o,
    input wire logic [1:0] periph_mode_i,
    input wire logic [7:0] reply_i,
    output logic rx_valid_o,
    output logic [7:0] rx_byte_o,
    spi_link_if.far link
);
    import spi_port_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Frame generator, mode 0, with half periods of HALF_CYC cycles.

    host_state_type hstate; // Generator state.
    logic [7:0] hcnt; // Cycles in the current half period.
    logic [5:0] hbit; // Bit index within the frame.
    logic [`HOST_FRAME_BITS-1:0] hsh; // Frame bits, first bit on top.
    logic [7:0] hrx; // Bits returned by the device.

    wire half_end = hcnt == 8'(HALF_CYC - 1);
    assign busy_o = hstate != H_IDLE;

    // Command, three address bytes and one data byte, top bit first.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hstate <= H_IDLE;
            hcnt <= 8'h00;
            hbit <= 6'h00;
            hsh <= '0;
            hrx <= 8'h00;
            rdata_o <= 8'h00;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            case (hstate)
                H_IDLE: begin
                    if (start_i) begin
                        hsh <= {read_i ? `CMD_READ : `CMD_WRITE, addr_i,
                            wdata_i};
                        hcnt <= 8'h00;
                        hbit <= 6'h00;
                        hstate <= H_LOW;
                    end
                end
                H_LOW: begin
                    hcnt <= half_end ? 8'h00 : hcnt + 8'h01;
                    if (half_end) begin
                        // Device changes on falling edges, so rising is safe.
                        hrx <= {hrx[6:0], link.dout};
                        hstate <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    hcnt <= half_end ? 8'h00 : hcnt + 8'h01;
                    if (half_end && hbit == 6'(`HOST_FRAME_BITS - 1)) begin
                        hstate <= H_IDLE;
                        rdata_o <= hrx;
                        done_o <= 1'b1;
                    end else if (half_end) begin
                        hbit <= hbit + 6'h01;
                        hsh <= {hsh[`HOST_FRAME_BITS-2:0], 1'b0};
                        hstate <= H_LOW;
                    end
                end
                default: begin
                    hstate <= H_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Peripheral answering a device in master mode.

    logic cs_q; // Chip-select one cycle ago.
    logic psck_q; // Clock one cycle ago.
    logic pout; // Bit driven back to the device.
    logic [7:0] ptx; // Reply bits still to send.
    logic [7:0] prx; // Bits received.
    logic [2:0] pcnt; // Bits in the current byte.

    wire periph_sel = !busy_o && !link.cs;
    wire p_cpha = periph_mode_i[1];
    wire p_edge = periph_sel && (link.serial_clock_pin != psck_q);
    wire p_lead = p_edge && (link.serial_clock_pin != periph_mode_i[0]);
    wire p_trail = p_edge && (link.serial_clock_pin == periph_mode_i[0]);
    wire p_cap = p_cpha ? p_trail : p_lead;
    wire p_shift = p_cpha ? p_lead : p_trail;

    // The reply byte is reloaded after each received byte.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cs_q <= 1'b1;
            psck_q <= 1'b0;
            pout <= 1'b0;
            ptx <= 8'h00;
            prx <= 8'h00;
            pcnt <= 3'h0;
            rx_valid_o <= 1'b0;
            rx_byte_o <= 8'h00;
        end else begin
            cs_q <= link.cs;
            psck_q <= link.serial_clock_pin;
            rx_valid_o <= 1'b0;
            if (cs_q && periph_sel) begin
                pcnt <= 3'h0;
                pout <= reply_i[7];
                ptx <= p_cpha ? reply_i : {reply_i[6:0], 1'b0};
            end else begin
                if (p_cap) begin
                    prx <= {prx[6:0], link.dout};
                    pcnt <= pcnt + 3'h1;
                    if (pcnt == 3'h7) begin
                        rx_valid_o <= 1'b1;
                        rx_byte_o <= {prx[6:0], link.dout};
                        ptx <= reply_i;
                    end
                end
                if (p_shift) begin
                    pout <= ptx[7];
                    ptx <= {ptx[6:0], 1'b0};
                end
            end
        end
    end

    assign link.far_cs_oe = busy_o;
    assign link.far_cs_o = 1'b0;
    assign link.far_sck_oe = busy_o;
    assign link.far_sck_o = hstate == H_HIGH;
    assign link.far_din_oe = busy_o || periph_sel;
    assign link.far_din_o = busy_o ? hsh[`HOST_FRAME_BITS-1] : pout;
endmodule // spi_port_host

// ---- tb/spi_port_props.sv ----
// Watches the shared link; both ends are design code.
module spi_port_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic dev_cs_oe,
    input wire logic dev_sck_o,
    input wire logic dev_sck_oe,
    input wire logic dev_dout_oe,
    input wire logic far_cs_oe,
    input wire logic far_sck_o,
    input wire logic cs,
    input wire logic serial_clock_pin,
    input wire logic dout
);
    timeunit 1ns;
    timeprecision 1ns;
    // One domain, so clock and reset are given once.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_reset_quiet: assert property ($fell(rst_i) |-> !dev_sck_oe &&
        !dev_cs_oe && !dev_dout_oe) else $error("device drives after reset");
    a_master_pins_pair: assert property (dev_sck_oe == dev_cs_oe)
        else $error("clock and select routed apart");
    // The bench runs the master divider at 3: an edge every 4 cycles.
    a_master_half_period: assert property (dev_sck_oe &&
        $changed(dev_sck_o) |=> $stable(dev_sck_o)[*3])
        else $error("master half period wrong");
    a_host_half_period: assert property (far_cs_oe &&
        $changed(far_sck_o) |=> $stable(far_sck_o)[*2])
        else $error("host clock too fast");
    a_host_idle_low: assert property (far_cs_oe && $fell(cs)
        |-> !serial_clock_pin) else $error("host frame not in mode 0");
    a_frame_select_held: assert property (far_cs_oe && $fell(cs)
        |=> !cs[*8]) else $error("frame select dropped early");
    a_slave_dout_framed: assert property (far_cs_oe && dev_dout_oe
        |-> !cs) else $error("slave drives outside frame");
    // A stray change while the clock is high breaks host capture.
    a_slave_dout_falling: assert property (far_cs_oe &&
        dev_dout_oe && $past(dev_dout_oe) && $changed(dout) |->
        !serial_clock_pin) else $error("slave data changed off falling edge");
    c_master_byte: cover property (dev_sck_oe && $changed(dev_sck_o));
    c_slave_read: cover property (far_cs_oe && dev_dout_oe);
    c_host_frame: cover property (far_cs_oe && $fell(cs));
endmodule // spi_port_props

// ---- tb/testbench.sv ----
`include "spi_port_consts.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, tw_i = 0;
    logic [7:0] adr_i = 0, rdata_o, reply_i = 8'h93, rx_byte_o, rx_seen = 0;
    logic [31:0] dat_i = 0, dat_o;
    logic ack_o, act_o, start_i = 0, read_i = 0, busy_o, done_o, rx_valid_o;
    logic [23:0] addr_i = 0;
    logic [7:0] wdata_i = 0, q, last = 0, doe_seen = 0;
    logic [1:0] periph_mode_i = 0;
    int fails = 0, samples_checked = 0, cycles = 0, edges = 0;
    spi_link_if link();
    spi_port_device spi_port_device_inst(.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .sel_i(4'h1),
        .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .two_wire_slave_i(tw_i), .serial_slave_active_o(act_o),
        .link(link.device));
    spi_port_host spi_port_host_inst(.clk_i(clk_i), .rst_i(rst_i),
        .start_i(start_i), .read_i(read_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .busy_o(busy_o), .done_o(done_o),
        .rdata_o(rdata_o), .periph_mode_i(periph_mode_i), .reply_i(reply_i),
        .rx_valid_o(rx_valid_o), .rx_byte_o(rx_byte_o), .link(link.far));
    spi_port_props spi_port_props_inst(.clk_i(clk_i), .rst_i(rst_i),
        .dev_cs_oe(link.dev_cs_oe), .dev_sck_o(link.dev_sck_o),
        .dev_sck_oe(link.dev_sck_oe), .dev_dout_oe(link.dev_dout_oe),
        .far_cs_oe(link.far_cs_oe), .far_sck_o(link.far_sck_o),
        .cs(link.cs), .serial_clock_pin(link.serial_clock_pin),
        .dout(link.dout));
    initial forever #25 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////////
    // Monitors: clock edges while the device drives, captures, timeout.
    always @(posedge clk_i) begin
        last <= link.serial_clock_pin;
        if (link.dev_sck_oe && link.serial_clock_pin !== last)
            edges <= edges + 1;
        if (rx_valid_o === 1'b1) rx_seen <= rx_byte_o;
        if (link.dev_dout_oe === 1'b1) doe_seen <= 8'h01;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            complete_run();
        end
    end
    task automatic complete_run();
        if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One classic cycle; entered just after an edge, leaves one idle cycle.
    task automatic bus(input logic w, input logic [3:0] i,
        input logic [7:0] d);
        cyc_i <= 1;
        stb_i <= 1;
        we_i <= w;
        adr_i <= {2'b00, i, 2'b00};
        dat_i <= {24'h0, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o[7:0];
        cyc_i <= 0;
        stb_i <= 0;
        @(posedge clk_i);
    endtask
    task automatic frame(input logic rd, input logic [23:0] a,
        input logic [7:0] d);
        start_i <= 1;
        read_i <= rd;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        start_i <= 0;
        do @(posedge clk_i); while (done_o !== 1'b1);
        @(posedge clk_i);
    endtask
    // Busy must show at once, then clear once the byte is out.
    task automatic wait_idle();
        bus(0, `REG_CTL_IDX, 0);
        check(q[6], 1);
        while (q[6] === 1'b1) bus(0, `REG_CTL_IDX, 0);
        repeat (2) @(posedge clk_i);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        bus(0, `REG_DATA_IDX, 0); check(q, 8'h00);
        bus(0, `REG_CTL_IDX, 0); check(q, 8'h11);
        bus(0, `REG_CFG_IDX, 0); check(q, 8'h05);
        bus(0, `REG_MODE_IDX, 0); check(q, 8'h00);
        bus(0, 4'h0, 0); check(q, 8'h00);
        // Link writes before the key are ignored.
        frame(0, 24'h8, 8'h3c);
        bus(0, `REG_DATA_IDX, 0); check(q, 8'h00);
        frame(0, 24'ha, 8'ha5); check(act_o, 1);
        frame(0, 24'h8, 8'h5a);
        bus(0, `REG_DATA_IDX, 0); check(q, 8'h5a);
        frame(1, 24'h8, 0); check(rdata_o, 8'h5a);
        tw_i <= 1;
        @(posedge clk_i);
        @(posedge clk_i); check(act_o, 0);
        tw_i <= 0;
        // Master with routing off, then on, at divider 3.
        bus(1, `REG_CFG_IDX, 8'h03);
        bus(1, `REG_CTL_IDX, 8'h02); check(link.dev_sck_oe, 0);
        bus(1, `REG_CFG_IDX, 8'h83); check(link.dev_sck_oe, 1);
        check(link.cs, 0);
        for (int m = 0; m < 4; m++) begin
            bus(1, `REG_CTL_IDX, 8'h03);
            bus(1, `REG_MODE_IDX, 8'(m));
            periph_mode_i <= 2'(m);
            bus(1, `REG_CTL_IDX, 8'h02);
            repeat (2) @(posedge clk_i);
            edges = 0;
            check(link.serial_clock_pin, 8'(m & 1));
            bus(1, `REG_DATA_IDX, 8'ha6 ^ 8'(m));
            wait_idle();
            check(rx_seen, 8'ha6 ^ 8'(m));
            check(8'(edges), 8'd16);
        end
        bus(1, `REG_CTL_IDX, 8'h0a);
        bus(0, `REG_DATA_IDX, 0);
        wait_idle();
        bus(0, `REG_DATA_IDX, 0); check(q, 8'h93);
        wait_idle();
        bus(1, `REG_CTL_IDX, 8'h06);
        edges = 0;
        doe_seen = 0;
        bus(0, `REG_DATA_IDX, 0);
        repeat (20) @(posedge clk_i); check(8'(edges), 8'd0);
        bus(1, `REG_DATA_IDX, 8'hff);
        wait_idle(); check(doe_seen, 8'h00);
        bus(1, `REG_CTL_IDX, 8'h2a);
        bus(0, `REG_DATA_IDX, 0);
        wait_idle();
        bus(0, `REG_DATA_IDX, 0); check(q, 8'h00);
        bus(1, `REG_CTL_IDX, 8'h03); check(link.cs, 1);
        complete_run();
    end
endmodule // testbench
